// ---- pkg/ext_bus_pkg.sv ----
package ext_bus_pkg;

  // Register map
  localparam logic [7:0] CONFIG_OFFSET     = 8'h00;
  localparam int         ADDR_WIDTH        = 8;
  localparam int         DATA_WIDTH        = 32;

  // Field positions in ext_interface_config_two
  localparam int         FILL_LSB          = 6;
  localparam int         FILL_MSB          = 7;
  localparam int         MODE_BIT          = 8;
  localparam int         INHIBIT_BIT       = 9;
  localparam int         REQUEST_SEEN_BIT  = 10;
  localparam int         GRANT_SEEN_BIT    = 11;

  // Values after reset, and the full fill level
  localparam logic       INHIBIT_RESET     = 1'b0;
  localparam logic       MODE_RESET        = 1'b0;
  localparam logic       REQUEST_IDLE_N    = 1'b1;
  localparam logic [1:0] FILL_EMPTY        = 2'h0;
  localparam logic [1:0] FILL_FULL         = 2'h3;

  // Cycles between a queue change and the reported level
  localparam int         FILL_LAG          = 2;

  typedef enum logic [1:0] {
    ARB_OWN     = 2'h1,
    ARB_GRANTED = 2'h2
  } arb_state_type;

endpackage

// ---- pkg/queue_level_if.sv ----
`timescale 1ns/1ps
interface queue_level_if;
  logic       push;
  logic       pop;
  logic       accept;
  logic [1:0] fill;

  modport owner (
    output push,
    output pop,
    input  accept,
    input  fill
  );

  modport level (
    input  push,
    input  pop,
    output accept,
    output fill
  );
endinterface

// ---- rtl/request_sync.sv ----
`timescale 1ns/1ps
module request_sync (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic async_in_n,
  output logic      sync_out_n
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_type;

  sync_state_type state_reg;
  sync_state_type state_next;

  always_comb begin
    state_next.meta   = async_in_n;
    state_next.stable = state_reg.meta; // [R19]
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= {ext_bus_pkg::REQUEST_IDLE_N, ext_bus_pkg::REQUEST_IDLE_N};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out_n = state_reg.stable;

  property p_sync_delay;
    @(posedge clock) disable iff (!reset_n)
      $past(reset_n, 2) |-> (sync_out_n == $past(async_in_n, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) // [R19]
    else $error("Request sync delay is not two cycles");

endmodule

// ---- rtl/write_queue_level.sv ----
`timescale 1ns/1ps
module write_queue_level (
  input  wire logic   clock,
  input  wire logic   reset_n,
  queue_level_if.level q
);

  typedef struct packed {
    logic [1:0]                               count;
    logic [ext_bus_pkg::FILL_LAG-1:0][1:0]    lag;
  } level_state_type;

  level_state_type state_reg;
  level_state_type state_next;
  logic            push_ok;

  // Full queue refuses a push unless an entry leaves in the same cycle
  assign push_ok = q.push && (q.accept);
  assign q.accept = (state_reg.count != ext_bus_pkg::FILL_FULL) || q.pop;

  always_comb begin
    state_next = state_reg;
    // Any write width occupies one entry [R2]
    if (push_ok && !(q.pop && state_reg.count != ext_bus_pkg::FILL_EMPTY)) begin
      state_next.count = state_reg.count + 2'h1;
    end else if (!push_ok && q.pop &&
                 state_reg.count != ext_bus_pkg::FILL_EMPTY) begin
      state_next.count = state_reg.count - 2'h1;
    end
    // Reported level trails the count on purpose [R3]
    state_next.lag = {state_reg.lag[ext_bus_pkg::FILL_LAG-2:0],
                      state_reg.count};
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q.fill = state_reg.lag[ext_bus_pkg::FILL_LAG-1]; // [R1]

  property p_fill_lag;
    @(posedge clock) disable iff (!reset_n)
      ##3 (q.fill == $past(state_reg.count, 2));
  endproperty
  a_fill_lag: assert property (p_fill_lag) // [R3]
    else $error("Reported fill does not trail count by two");

  property p_push_counts;
    @(posedge clock) disable iff (!reset_n)
      (q.push && q.accept && !q.pop) |=>
        (state_reg.count == $past(state_reg.count) + 2'h1);
  endproperty
  a_push_counts: assert property (p_push_counts) // [R2]
    else $error("Accepted push did not add one entry");

endmodule

// ---- rtl/ext_bus_grant_and_mode_ctrl.sv ----
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Function
// R1: Two-bit read-only fill level: 00 empty, up to three waiting writes.
// R2: Each waiting write, of any width, counts as one entry.
// R3: Reported fill may trail the queue contents by a few cycles.
// R4: Mode bit 8 is loaded from the boot mode pin at reset.
// R5: Software writes the mode bit; the mode output pin follows it.
// R6: Mode 1 enables top external zone, disables boot ROM; 0 the reverse.
// R7: After reset the boot mode pin is ignored; only writes change mode.
// R8: Outside master bus_request_seen request low for as long as it needs the bus.
// R9: Inhibit bit 9 low: a low request is granted automatically.
// R10: Inhibit bit high: no grant, grant output stays high.
// R11: Setting inhibit while granted releases grant and drives the bus again.
// R12: Inhibit bit clears to zero on reset.
// R13: Request low during reset: bus released, grant driven low.
// R14: Core keeps running from internal memory while the bus is granted.
// R15: Core external access while granted gets not-ready until request ends.
// R16: Read-only bit 10 shows the request input level.
// R17: Read-only bit 11 shows the grant output level.
// R18: Software changes queue depth only while the fill level shows empty.
// R19: Request input passes a two-stage synchroniser before use.
module ext_bus_grant_and_mode_ctrl (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic        boot_mode_pin,
  output logic             processor_mode_select,
  output logic             zone_top_enable,
  output logic             boot_rom_enable,
  input  wire logic        bus_request_in_n,
  output logic             bus_grant_out_n,
  output logic             ext_bus_drive_en,
  input  wire logic        write_enter,
  output logic             write_enter_ready,
  input  wire logic        write_leave,
  input  wire logic        core_ext_req,
  output logic             core_ext_ready
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    ext_bus_pkg::arb_state_type arb;
    logic                       mode;
    logic                       inhibit;
    logic                       strap_pending;
    logic [31:0]                rdata;
  } ctrl_state_type;

  ctrl_state_type state_reg;
  ctrl_state_type state_next;

  logic           request_sync_n;
  logic           config_hit;
  logic           config_write;
  logic           config_read;
  logic           granted;

  queue_level_if  queue_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_config(input logic [7:0] addr);
    is_config = (addr == ext_bus_pkg::CONFIG_OFFSET);
  endfunction

  function automatic logic [31:0] config_image(
    input logic [1:0] fill,
    input logic       mode,
    input logic       inhibit,
    input logic       request_n,
    input logic       grant_n
  );
    logic [31:0] image;
    image = 32'h0000_0000;
    image[ext_bus_pkg::FILL_MSB:ext_bus_pkg::FILL_LSB] = fill;
    image[ext_bus_pkg::MODE_BIT]         = mode;
    image[ext_bus_pkg::INHIBIT_BIT]      = inhibit;
    image[ext_bus_pkg::REQUEST_SEEN_BIT] = request_n;
    image[ext_bus_pkg::GRANT_SEEN_BIT]   = grant_n;
    config_image = image;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  request_sync u_request_sync (
    .clock      (clock),
    .reset_n    (reset_n),
    .async_in_n (bus_request_in_n),
    .sync_out_n (request_sync_n)
  );

  write_queue_level u_write_queue_level (
    .clock   (clock),
    .reset_n (reset_n),
    .q       (queue_bus.level)
  );

  assign queue_bus.push    = write_enter;
  assign queue_bus.pop     = write_leave;
  assign write_enter_ready = queue_bus.accept;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  assign config_hit   = is_config(reg_addr);
  assign config_write = reg_write && config_hit;
  assign config_read  = reg_read && config_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;
    state_next.strap_pending = 1'b0;
    state_next.rdata = 32'h0000_0000;

    // Strap caught at the first edge after release, never later [R4] [R7]
    if (state_reg.strap_pending) begin
      state_next.mode = boot_mode_pin;
    end

    // A write in the strap cycle still wins over the pin
    if (config_write) begin
      state_next.mode    = reg_wdata[ext_bus_pkg::MODE_BIT]; // [R5]
      state_next.inhibit = reg_wdata[ext_bus_pkg::INHIBIT_BIT];
    end

    // Inhibit takes effect at the same edge as its write [R9] [R10] [R11]
    case (state_reg.arb)
      ext_bus_pkg::ARB_OWN: begin
        if (!request_sync_n && !state_next.inhibit) begin
          state_next.arb = ext_bus_pkg::ARB_GRANTED;
        end
      end
      ext_bus_pkg::ARB_GRANTED: begin
        // Master keeps request low while it owns the bus [R8]
        if (request_sync_n || state_next.inhibit) begin
          state_next.arb = ext_bus_pkg::ARB_OWN;
        end
      end
      default: begin
        state_next.arb = ext_bus_pkg::ARB_OWN;
      end
    endcase

    // Synchronised request level in bit 10, live grant output in bit 11 [R16] [R17] [R1]
    if (config_read) begin
      state_next.rdata = config_image(queue_bus.fill, state_reg.mode,
                                      state_reg.inhibit, request_sync_n,
                                      bus_grant_out_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg.arb           <= ext_bus_pkg::ARB_OWN;
      state_reg.mode          <= ext_bus_pkg::MODE_RESET;
      state_reg.inhibit       <= ext_bus_pkg::INHIBIT_RESET; // [R12]
      state_reg.strap_pending <= 1'b1;
      state_reg.rdata         <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign granted = (state_reg.arb == ext_bus_pkg::ARB_GRANTED);

  // During reset the grant follows the pin directly; no clock is assumed
  always_comb begin
    if (!reset_n) begin
      bus_grant_out_n = bus_request_in_n; // [R13]
    end else begin
      bus_grant_out_n = !granted;
    end
  end

  // Bus and strobes float exactly while the grant is low [R13] [R11]
  assign ext_bus_drive_en = bus_grant_out_n;

  // Only external accesses stall; internal fetches never see this [R14]
  assign core_ext_ready = bus_grant_out_n; // [R15]

  assign processor_mode_select = state_reg.mode; // [R5]
  assign zone_top_enable       = state_reg.mode; // [R6]
  assign boot_rom_enable       = !state_reg.mode; // [R6]
  assign reg_rdata             = state_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_granted_now;
    !bus_grant_out_n;
  endsequence

  sequence s_inhibit_set;
    config_write && reg_wdata[ext_bus_pkg::INHIBIT_BIT];
  endsequence

  property p_strap_load;
    @(posedge clock) disable iff (!reset_n)
      (state_reg.strap_pending && !config_write) |=>
        (processor_mode_select == $past(boot_mode_pin));
  endproperty
  a_strap_load: assert property (p_strap_load) // [R4]
    else $error("Mode not loaded from boot pin after reset");

  property p_mode_write;
    @(posedge clock) disable iff (!reset_n)
      config_write |=>
        (processor_mode_select == $past(reg_wdata[ext_bus_pkg::MODE_BIT]));
  endproperty
  a_mode_write: assert property (p_mode_write) // [R5]
    else $error("Mode pin does not follow written value");

  property p_zone_map;
    @(posedge clock) disable iff (!reset_n)
      (zone_top_enable == processor_mode_select) &&
      (boot_rom_enable == !processor_mode_select);
  endproperty
  a_zone_map: assert property (p_zone_map) // [R6]
    else $error("Zone and boot ROM mapping disagree with mode");

  property p_mode_hold;
    @(posedge clock) disable iff (!reset_n)
      (!state_reg.strap_pending && !config_write) |=>
        $stable(processor_mode_select);
  endproperty
  a_mode_hold: assert property (p_mode_hold) // [R7]
    else $error("Mode changed without a write");

  property p_auto_grant;
    @(posedge clock) disable iff (!reset_n)
      (!request_sync_n && !state_reg.inhibit && !config_write) |=>
        s_granted_now;
  endproperty
  a_auto_grant: assert property (p_auto_grant) // [R9]
    else $error("Pending request not granted while allowed");

  property p_inhibit_blocks;
    @(posedge clock) disable iff (!reset_n)
      (state_reg.inhibit && !config_write) |-> bus_grant_out_n [*2];
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks) // [R10]
    else $error("Grant given while inhibited");

  property p_inhibit_release;
    @(posedge clock) disable iff (!reset_n)
      (s_granted_now and s_inhibit_set) |=>
        (bus_grant_out_n && ext_bus_drive_en);
  endproperty
  a_inhibit_release: assert property (p_inhibit_release) // [R11]
    else $error("Grant not released one cycle after inhibit");

  property p_inhibit_reset;
    @(posedge clock) disable iff (!reset_n)
      state_reg.strap_pending |-> !state_reg.inhibit;
  endproperty
  a_inhibit_reset: assert property (p_inhibit_reset) // [R12]
    else $error("Inhibit not clear after reset");

  property p_reset_float;
    @(posedge clock) disable iff (1'b0)
      !reset_n |-> ((bus_grant_out_n == bus_request_in_n) &&
                    (ext_bus_drive_en == bus_request_in_n));
  endproperty
  a_reset_float: assert property (p_reset_float) // [R13]
    else $error("Reset grant or bus float wrong");

  property p_core_stall;
    @(posedge clock) disable iff (!reset_n)
      (core_ext_req && !core_ext_ready && !request_sync_n &&
       !config_write) |=> !core_ext_ready;
  endproperty
  a_core_stall: assert property (p_core_stall) // [R15]
    else $error("Core access not stalled while bus granted");

  property p_grant_wait_bounded;
    @(posedge clock) disable iff (!reset_n)
      (granted && request_sync_n) |=> !granted;
  endproperty
  a_grant_wait_bounded: assert property (p_grant_wait_bounded) // [R15]
    else $error("Grant held after request removed");

  property p_no_unrequested_grant;
    @(posedge clock) disable iff (!reset_n)
      (!granted && request_sync_n) |=> !granted;
  endproperty
  a_no_unrequested_grant: assert property (p_no_unrequested_grant) // [R9]
    else $error("Grant given without a request");

  property p_inhibit_by_write;
    @(posedge clock) disable iff (!reset_n)
      !config_write |=> $stable(state_reg.inhibit);
  endproperty
  a_inhibit_by_write: assert property (p_inhibit_by_write) // [R10]
    else $error("Inhibit changed without a write");

  property p_request_seen;
    @(posedge clock) disable iff (!reset_n)
      config_read |=>
        (reg_rdata[ext_bus_pkg::REQUEST_SEEN_BIT] == $past(request_sync_n));
  endproperty
  a_request_seen: assert property (p_request_seen) // [R16]
    else $error("Request status bit wrong");

  property p_grant_seen;
    @(posedge clock) disable iff (!reset_n)
      config_read |=>
        (reg_rdata[ext_bus_pkg::GRANT_SEEN_BIT] == $past(bus_grant_out_n));
  endproperty
  a_grant_seen: assert property (p_grant_seen) // [R17]
    else $error("Grant status bit wrong");

  property p_unmapped_zero;
    @(posedge clock) disable iff (!reset_n)
      !config_read |=> (reg_rdata == 32'h0000_0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("Read data not zero outside a config read");

  property p_fill_reported;
    @(posedge clock) disable iff (!reset_n)
      config_read |=>
        (reg_rdata[ext_bus_pkg::FILL_MSB:ext_bus_pkg::FILL_LSB] ==
         $past(queue_bus.fill));
  endproperty
  a_fill_reported: assert property (p_fill_reported) // [R1]
    else $error("Fill level field wrong");

endmodule

// ---- sim/ext_master_model.sv ----
`timescale 1ns/1ps
module ext_master_model (
  input  wire logic clock,
  input  wire logic want_bus,
  output logic      bus_request_in_n
);
  // Request follows the wish one edge late, as an outside master would
  initial bus_request_in_n = 1'b1;
  always @(posedge clock) begin
    bus_request_in_n <= !want_bus;
  end
endmodule

// ---- sim/tb_ext_bus_grant_and_mode_ctrl.sv ----
`timescale 1ns/1ps
module tb_ext_bus_grant_and_mode_ctrl;
  logic        clock;
  logic        reset_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic        boot_mode_pin;
  logic        processor_mode_select;
  logic        zone_top_enable;
  logic        boot_rom_enable;
  logic        bus_request_in_n;
  logic        bus_grant_out_n;
  logic        ext_bus_drive_en;
  logic        write_enter;
  logic        write_enter_ready;
  logic        write_leave;
  logic        core_ext_req;
  logic        core_ext_ready;
  logic        want_bus;
  int          failures;
  int          n_tests;
  int          cycles;

  ext_bus_grant_and_mode_ctrl dut (
    .clock                 (clock),
    .reset_n               (reset_n),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_write             (reg_write),
    .reg_read              (reg_read),
    .reg_rdata             (reg_rdata),
    .boot_mode_pin         (boot_mode_pin),
    .processor_mode_select (processor_mode_select),
    .zone_top_enable       (zone_top_enable),
    .boot_rom_enable       (boot_rom_enable),
    .bus_request_in_n      (bus_request_in_n),
    .bus_grant_out_n       (bus_grant_out_n),
    .ext_bus_drive_en      (ext_bus_drive_en),
    .write_enter           (write_enter),
    .write_enter_ready     (write_enter_ready),
    .write_leave           (write_leave),
    .core_ext_req          (core_ext_req),
    .core_ext_ready        (core_ext_ready)
  );

  ext_master_model master (
    .clock            (clock),
    .want_bus         (want_bus),
    .bus_request_in_n (bus_request_in_n)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("failures %0d, comparisons %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic check_mode(input logic m);
    check({29'h0, processor_mode_select, zone_top_enable, boot_rom_enable},
          {29'h0, m, m, !m});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_mode;
    @(posedge clock);
    #1;
    check_mode(1'b1);
    boot_mode_pin <= 1'b0;
    want_bus      <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    check_mode(1'b1);
    reg_rd(8'h00, 32'h00000d00);
    reg_wr(8'h00, 32'h00000000);
    check_mode(1'b0);
    // Unmapped place and read-only bits must not disturb the word
    reg_wr(8'h04, 32'hffffffff);
    reg_wr(8'h00, 32'h00000cc0);
    reg_rd(8'h04, 32'h00000000);
    reg_rd(8'h00, 32'h00000c00);
  endtask

  task automatic t_grant;
    core_ext_req <= 1'b1;
    @(posedge clock);
    want_bus <= 1'b1;
    @(posedge clock);
    repeat (2) @(posedge clock);
    #1;
    check(bus_grant_out_n, 1'b1);
    @(posedge clock);
    #1;
    check({ext_bus_drive_en, bus_grant_out_n}, 2'h0);
    check(core_ext_ready, 1'b0);
    reg_rd(8'h00, 32'h00000000);
    reg_wr(8'h00, 32'h00000200);
    check({ext_bus_drive_en, bus_grant_out_n}, 2'h3);
    repeat (5) @(posedge clock);
    #1;
    check(bus_grant_out_n, 1'b1);
    reg_rd(8'h00, 32'h00000a00);
    reg_wr(8'h00, 32'h00000000);
    repeat (2) @(posedge clock);
    #1;
    check(bus_grant_out_n, 1'b0);
    want_bus <= 1'b0;
    @(posedge clock);
    repeat (2) @(posedge clock);
    #1;
    check(core_ext_ready, 1'b0);
    @(posedge clock);
    #1;
    check({core_ext_ready, bus_grant_out_n}, 2'h3);
    core_ext_req <= 1'b0;
  endtask

  task automatic t_queue;
    @(posedge clock);
    write_enter <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check(write_enter_ready, 1'b0);
    @(posedge clock);
    write_enter <= 1'b0;
    repeat (3) @(posedge clock);
    reg_rd(8'h00, 32'h00000cc0);
    @(posedge clock);
    write_leave <= 1'b1;
    @(posedge clock);
    write_leave <= 1'b0;
    repeat (3) @(posedge clock);
    reg_rd(8'h00, 32'h00000c80);
    @(posedge clock);
    write_leave <= 1'b1;
    repeat (3) @(posedge clock);
    write_leave <= 1'b0;
    repeat (3) @(posedge clock);
    reg_rd(8'h00, 32'h00000c00);
  endtask

  // Mid-run reset with inhibit set and no request pending
  task automatic t_reset;
    reg_wr(8'h00, 32'h00000200);
    @(posedge clock);
    reset_n       <= 1'b0;
    boot_mode_pin <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check({ext_bus_drive_en, bus_grant_out_n}, 2'h3);
    check({core_ext_ready, write_enter_ready}, 2'h3);
    check_mode(1'b0);
    @(posedge clock);
    reset_n <= 1'b1;
    reg_rd(8'h00, 32'h00000d00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures      = 0;
    n_tests       = 0;
    cycles        = 0;
    reset_n       = 1'b0;
    reg_addr      = 8'h00;
    reg_wdata     = 32'h00000000;
    reg_write     = 1'b0;
    reg_read      = 1'b0;
    boot_mode_pin = 1'b1;
    write_enter   = 1'b0;
    write_leave   = 1'b0;
    core_ext_req  = 1'b0;
    want_bus      = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check({ext_bus_drive_en, bus_grant_out_n}, 2'h0);
    @(posedge clock);
    reset_n <= 1'b1;
    t_mode();
    t_grant();
    t_queue();
    t_reset();
    test_done();
  end
endmodule
